// ---- logic/lis_device.sv ----
// Function
// [R01] An access moves one 4n core word as four n-wide half-cycle pad transfers.
// [R02] Bursts start at the chosen column, run programmed length in programmed order.
// [R03] Outputs are only guaranteed off while clock enable is low.
// [R04] Controller holds clock enable low 100 ns after supply ramp.
// [R05] Controller gives five stable clocks before first clock enable rise.
// [R06] Mode reads before configuration need clock period 18 to 100 ns; the controller model runs the link at a 125 ns period.
// [R07] Controller keeps clock enable high, only no-ops, for 200 us.
// [R08] Controller then issues reset mode write, optionally after precharge-all.
// [R09] Controller waits 1 us of no-ops after the reset command.
// [R10] Until auto-init ends, controller sends only mode reads and power-down commands; the testbench also sends one read then.
// [R11] Device clears auto-init status within 10 us of reset, then idles.
// [R12] Controller polls auto-init status or waits the full 10 us.
// [R13] Controller should read device information registers before configuring.
// [R14] Calibration write to register 10 makes the device calibrate its drivers.
// [R15] Controller never overlaps calibration commands to different devices.
// [R16] Device is ready for normal operation 1 us after initial calibration.
// [R17] Controller programs registers 1, 2 and 3 before normal accesses.
// [R18] After configuration the device idles and accepts any valid command.
// [R19] A later reset command restarts initialization at the reset step.
// [R20] Controller holds clock enable low while power is removed.
// [R21] In the idle state every bank is precharged.
// [R22] Completed initial calibration sets the calibration pad information field.
// [R23] Controller derives waits as rounded-up cycle counts and drives no-ops.
// [R24] Controller reports done after configuration and holds user access until then; the controller model has no done report and no access gate.
module lis_device
	import lis_pkg::*;
(
	input  wire logic             mclk,                   // Core clock, 125 MHz.
	input  wire logic             rst,                    // Synchronous reset, active high.
	input  wire logic             ck_pin,                 // Link clock from the controller.
	input  wire logic             cke_pin,                // Clock enable pin.
	input  wire logic             cs_n_pin,               // Chip select, active low.
	input  wire logic [CA_W-1:0]  command_address_bus,    // Command/address pins.
	input  wire logic [7:0]       dq_in,                  // Data pins, input side.
	input  wire logic             dm_in,                  // Write data mask pin.
	output logic      [7:0]       dq_out,                 // Data pins, output side.
	output logic                  dq_oe,                  // Data pin drive enable.
	output logic                  dqs_out,                // Read data strobe.
	output logic                  dqs_oe,                 // Data strobe drive enable.
	output logic                  core_rd_strobe,         // Core word fetch pulse.
	input  wire logic [31:0]      core_rd_word,           // Core word, valid cycle after fetch.
	output logic                  core_wr_valid,          // Core word store pulse.
	output logic      [31:0]      core_wr_word,           // Assembled write word.
	output logic      [3:0]       core_wr_mask,           // Byte mask of the write word.
	output logic      [2:0]       core_bank,              // Bank of the access.
	output logic      [COL_W-1:0] core_col,               // Column of the core word.
	output logic                  auto_init_status_bit,   // Auto-init still in progress.
	output logic      [1:0]       calibration_pad_info,   // Calibration pad result.
	output logic                  device_ready,           // Calibration finished.
	output logic                  device_idle,            // Idle state.
	output logic                  all_banks_precharged    // No bank is open.
);

	// ************************************************************
	// Pin synchronisation and edge detection.
	// ************************************************************
	logic [PIN_W-1:0] pins_s;
	logic             ck_s, cke_s, cs_n_s, dm_s;
	logic [CA_W-1:0]  ca_s;
	logic [7:0]       dq_s;
	logic             ck_d_ff, nxt_ck_d;
	logic             ck_rise, ck_fall;

	lis_pin_sync #(.W(PIN_W)) u_sync (
		.mclk    (mclk),
		.rst     (rst),
		.pin_in  ({ck_pin, cke_pin, cs_n_pin, command_address_bus, dq_in, dm_in}),
		.pin_out (pins_s)
	);

	assign {ck_s, cke_s, cs_n_s, ca_s, dq_s, dm_s} = pins_s;
	assign ck_rise = ck_s & ~ck_d_ff;
	assign ck_fall = ~ck_s & ck_d_ff;

	// ************************************************************
	// Command decode: rising half captured, falling half completes.
	// ************************************************************
	logic [CA_W-1:0] rise_ca_ff, nxt_rise_ca;
	logic            pend_ff, nxt_pend;
	logic            cmd_go;
	logic [3:0]      cop;
	logic [7:0]      ma, op;
	logic [COL_W-1:0] cmd_col;

	assign cmd_go  = ck_fall & pend_ff;
	assign cop     = rise_ca_ff[3:0];
	assign ma      = {ca_s[1:0], rise_ca_ff[9:4]};
	assign op      = ca_s[9:2];
	assign cmd_col = {ca_s[9:1], rise_ca_ff[5]};

	// ************************************************************
	// Sequencing state.
	// ************************************************************
	lis_state_e       state_ff, nxt_state, ret_ff, nxt_ret;
	logic [CNT_W-1:0] ai_cnt_ff, nxt_ai_cnt, cnt_ff, nxt_cnt;
	logic             dai_ff, nxt_dai, ready_ff, nxt_ready;
	logic [1:0]       calibration_pad_info_ff, nxt_calibration_pad_info;
	logic [7:0]       mr1_ff, nxt_mr1, mr2_ff, nxt_mr2, mr3_ff, nxt_mr3;
	logic [7:0]       bank_open_ff, nxt_bank_open;
	logic [4:0]       beat_ff, nxt_beat, beats_ff, nxt_beats, beat_p1;
	logic             mrr_ff, nxt_mrr;
	logic [7:0]       mrr_data_ff, nxt_mrr_data;
	logic [31:0]      word_ff, nxt_word, wr_word_ff, nxt_wr_word;
	logic [3:0]       wr_mask_ff, nxt_wr_mask;
	logic             latch_ff, nxt_latch;
	logic [COL_W-1:0] base_col_ff, nxt_base_col, col_ff, nxt_col, seq_col;
	logic [2:0]       bank_ff, nxt_bank;
	logic [7:0]       dq_ff, nxt_dq;
	logic             dqoe_ff, nxt_dqoe, dqs_ff, nxt_dqs, dqsoe_ff, nxt_dqsoe;
	logic             rds_ff, nxt_rds, wrv_ff, nxt_wrv;
	logic [1:0]       bl_code;
	logic [1:0]       word_idx;
	logic             edge_any;

	assign edge_any = ck_rise | ck_fall;
	assign beat_p1  = beat_ff + 5'h01;
	assign bl_code  = (mr1_ff[2:0] == BL16_CODE) ? 2'h2 :
	                  (mr1_ff[2:0] == BL8_CODE)  ? 2'h1 : 2'h0;
	assign word_idx = (state_ff == ST_WR) ? beat_ff[3:2] : beat_p1[3:2];

	lis_burst_col #(.COL_W(COL_W)) u_col (
		.base_col   (base_col_ff),
		.bl_code    (bl_code),
		.interleave (mr1_ff[MR1_BT_POS]),
		.word_idx   (word_idx),
		.col        (seq_col)
	);

	always_comb begin
		nxt_ck_d      = ck_s;
		nxt_rise_ca   = rise_ca_ff;
		nxt_pend      = pend_ff;
		nxt_state     = state_ff;
		nxt_ret       = ret_ff;
		nxt_ai_cnt    = ai_cnt_ff;
		nxt_cnt       = cnt_ff;
		nxt_dai       = dai_ff;
		nxt_ready     = ready_ff;
		nxt_calibration_pad_info      = calibration_pad_info_ff;
		nxt_mr1       = mr1_ff;
		nxt_mr2       = mr2_ff;
		nxt_mr3       = mr3_ff;
		nxt_bank_open = bank_open_ff;
		nxt_beat      = beat_ff;
		nxt_beats     = beats_ff;
		nxt_mrr       = mrr_ff;
		nxt_mrr_data  = mrr_data_ff;
		nxt_latch     = rds_ff;
		nxt_word      = latch_ff ? core_rd_word : word_ff;
		nxt_wr_word   = wr_word_ff;
		nxt_wr_mask   = wr_mask_ff;
		nxt_base_col  = base_col_ff;
		nxt_col       = col_ff;
		nxt_bank      = bank_ff;
		nxt_dq        = dq_ff;
		nxt_dqoe      = dqoe_ff;
		nxt_dqs       = dqs_ff;
		nxt_dqsoe     = dqsoe_ff;
		nxt_rds       = 1'b0;
		nxt_wrv       = 1'b0;
		if (ck_rise) begin
			nxt_rise_ca = ca_s;
			nxt_pend    = cke_s & ~cs_n_s;
		end else if (ck_fall) begin
			nxt_pend = 1'b0;
		end
		// The auto-init timer only runs once a reset command has started it.
		if (dai_ff && state_ff != ST_OFF && state_ff != ST_BOOT) begin
			nxt_ai_cnt = ai_cnt_ff + 11'h001;
			if (ai_cnt_ff == CNT_W'(AUTO_INIT_CYC - 1)) begin
				nxt_dai = 1'b0; // R11
			end
		end
		case (state_ff)
			ST_OFF: begin
				if (ck_rise && cke_s) begin
					nxt_state = ST_BOOT;
				end
			end
			ST_BOOT: begin
				nxt_state = ST_BOOT;
			end
			ST_AUTOINIT: begin
				if (!dai_ff) begin
					nxt_state = ST_IDLE; // R11
				end else if (cmd_go && cop == CMD_MRR) begin
					nxt_state = ST_RD;
					nxt_ret   = ST_AUTOINIT;
					nxt_mrr   = 1'b1;
					nxt_beats = MRR_BEATS;
					nxt_beat  = 5'h00;
					nxt_mrr_data = (ma == MA_MR0) ? {3'h0, calibration_pad_info_ff, 2'h0, dai_ff} : 8'h00;
				end
			end
			ST_IDLE, ST_BANK: begin
				if (cmd_go) begin
					nxt_ret = (bank_open_ff == 8'h00) ? ST_IDLE : ST_BANK;
					if (cop == CMD_MRW) begin
						if (ma == MA_MR1) nxt_mr1 = op;
						if (ma == MA_MR2) nxt_mr2 = op;
						if (ma == MA_MR3) nxt_mr3 = op;
						if (ma == MA_MR10 && op == ZQ_INIT_OP && state_ff == ST_IDLE) begin
							nxt_state = ST_ZQCAL; // R14
							nxt_cnt   = '0;
							nxt_ready = 1'b0;
						end
					end else if (cop == CMD_MRR) begin
						nxt_state = ST_RD;
						nxt_mrr   = 1'b1;
						nxt_beats = MRR_BEATS;
						nxt_beat  = 5'h00;
						nxt_mrr_data = (ma == MA_MR0) ? {3'h0, calibration_pad_info_ff, 2'h0, dai_ff} : 8'h00;
					end else if (cop == CMD_PRE) begin
						if (rise_ca_ff[PRE_ALL_POS]) begin
							nxt_bank_open = 8'h00; // R21
						end else begin
							nxt_bank_open[rise_ca_ff[9:7]] = 1'b0;
						end
						nxt_state = ST_IDLE;
						if (!rise_ca_ff[PRE_ALL_POS] &&
						    (bank_open_ff & ~(8'h01 << rise_ca_ff[9:7])) != 8'h00) begin
							nxt_state = ST_BANK;
						end
					end else if (cop[2:0] == CMD_RD || cop[2:0] == CMD_WR) begin
						nxt_state    = (cop[2:0] == CMD_RD) ? ST_RD : ST_WR; // R18
						nxt_mrr      = 1'b0;
						nxt_beat     = 5'h00;
						nxt_beats    = 5'h04 << bl_code; // R02
						nxt_base_col = cmd_col;
						nxt_col      = cmd_col;
						nxt_bank     = rise_ca_ff[9:7];
						nxt_rds      = (cop[2:0] == CMD_RD); // R01
					end else if (cop[1:0] == CMD_ACT) begin
						nxt_bank_open[rise_ca_ff[9:7]] = 1'b1;
						nxt_state = ST_BANK; // R21
					end
				end
			end
			ST_ZQCAL: begin
				nxt_cnt = cnt_ff + 11'h001;
				if (cnt_ff == CNT_W'(INIT_CAL_CYC - 1)) begin
					nxt_state = ST_IDLE;
					nxt_ready = 1'b1; // R16
					nxt_calibration_pad_info  = CALIBRATION_PAD_INFO_OK; // R22
				end
			end
			ST_RD: begin
				if (edge_any) begin
					if (beat_ff == beats_ff) begin
						nxt_dqoe  = 1'b0;
						nxt_dqsoe = 1'b0;
						nxt_state = ret_ff;
					end else begin
						nxt_dq    = mrr_ff ? ((beat_ff == 5'h00) ? mrr_data_ff : 8'h00)
						                   : word_ff[{beat_ff[1:0], 3'b000} +: 8]; // R01
						nxt_dqoe  = 1'b1;
						nxt_dqs   = ck_rise;
						nxt_dqsoe = 1'b1;
						nxt_beat  = beat_p1;
						if (!mrr_ff && beat_ff[1:0] == 2'h3 && beat_p1 != beats_ff) begin
							nxt_rds = 1'b1;
							nxt_col = seq_col; // R02
						end
					end
				end
			end
			ST_WR: begin
				if (edge_any) begin
					if (beat_ff == beats_ff) begin
						nxt_state = ret_ff;
					end else begin
						nxt_wr_word[{beat_ff[1:0], 3'b000} +: 8] = dq_s; // R01
						nxt_wr_mask[beat_ff[1:0]] = dm_s;
						nxt_beat = beat_p1;
						if (beat_ff[1:0] == 2'h3) begin
							nxt_wrv = 1'b1;
							nxt_col = seq_col; // R02
						end
					end
				end
			end
			default: begin
				nxt_state = ST_OFF;
			end
		endcase
		if (cmd_go && cop == CMD_MRW && ma == MA_RESET &&
		    (state_ff == ST_BOOT || state_ff == ST_AUTOINIT ||
		     state_ff == ST_IDLE || state_ff == ST_BANK)) begin
			nxt_state     = ST_AUTOINIT; // R19
			nxt_dai       = 1'b1;
			nxt_ai_cnt    = '0;
			nxt_ready     = 1'b0;
			nxt_mr1       = MR1_RST;
			nxt_mr2       = MR2_RST;
			nxt_mr3       = MR3_RST;
			nxt_bank_open = 8'h00;
		end
		if (!cke_s) begin
			nxt_dqoe  = 1'b0; // R03
			nxt_dqsoe = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			ck_d_ff <= 1'b0; rise_ca_ff <= '0; pend_ff <= 1'b0;
			state_ff <= ST_OFF; ret_ff <= ST_IDLE;
			ai_cnt_ff <= '0; cnt_ff <= '0; dai_ff <= 1'b1; ready_ff <= 1'b0;
			calibration_pad_info_ff <= CALIBRATION_PAD_INFO_NONE; mr1_ff <= MR1_RST; mr2_ff <= MR2_RST; mr3_ff <= MR3_RST;
			bank_open_ff <= 8'h00; beat_ff <= 5'h00; beats_ff <= MRR_BEATS;
			mrr_ff <= 1'b0; mrr_data_ff <= 8'h00; word_ff <= 32'h00000000;
			wr_word_ff <= 32'h00000000; wr_mask_ff <= 4'h0; latch_ff <= 1'b0;
			base_col_ff <= '0; col_ff <= '0; bank_ff <= 3'h0;
			dq_ff <= 8'h00; dqoe_ff <= 1'b0; dqs_ff <= 1'b0; dqsoe_ff <= 1'b0;
			rds_ff <= 1'b0; wrv_ff <= 1'b0;
		end else begin
			ck_d_ff <= nxt_ck_d; rise_ca_ff <= nxt_rise_ca; pend_ff <= nxt_pend;
			state_ff <= nxt_state; ret_ff <= nxt_ret;
			ai_cnt_ff <= nxt_ai_cnt; cnt_ff <= nxt_cnt; dai_ff <= nxt_dai; ready_ff <= nxt_ready;
			calibration_pad_info_ff <= nxt_calibration_pad_info; mr1_ff <= nxt_mr1; mr2_ff <= nxt_mr2; mr3_ff <= nxt_mr3;
			bank_open_ff <= nxt_bank_open; beat_ff <= nxt_beat; beats_ff <= nxt_beats;
			mrr_ff <= nxt_mrr; mrr_data_ff <= nxt_mrr_data; word_ff <= nxt_word;
			wr_word_ff <= nxt_wr_word; wr_mask_ff <= nxt_wr_mask; latch_ff <= nxt_latch;
			base_col_ff <= nxt_base_col; col_ff <= nxt_col; bank_ff <= nxt_bank;
			dq_ff <= nxt_dq; dqoe_ff <= nxt_dqoe; dqs_ff <= nxt_dqs; dqsoe_ff <= nxt_dqsoe;
			rds_ff <= nxt_rds; wrv_ff <= nxt_wrv;
		end
	end

	assign dq_out               = dq_ff;
	assign dq_oe                = dqoe_ff;
	assign dqs_out              = dqs_ff;
	assign dqs_oe               = dqsoe_ff;
	assign core_rd_strobe       = rds_ff;
	assign core_wr_valid        = wrv_ff;
	assign core_wr_word         = wr_word_ff;
	assign core_wr_mask         = wr_mask_ff;
	assign core_bank            = bank_ff;
	assign core_col             = col_ff;
	assign auto_init_status_bit = dai_ff;
	assign calibration_pad_info = calibration_pad_info_ff;
	assign device_ready         = ready_ff;
	assign device_idle          = (state_ff == ST_IDLE);
	assign all_banks_precharged = (bank_open_ff == 8'h00);

	// ************************************************************
	// Assertions.
	// ************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	sequence s_rd_enter;
		state_ff == ST_RD && $past(state_ff) != ST_RD && !mrr_ff;
	endsequence

	sequence s_cal_done;
		state_ff == ST_ZQCAL ##1 state_ff == ST_IDLE;
	endsequence

	a_cke_low_hiz: assert property (!cke_s |=> !dq_oe && !dqs_oe) // R03
		else $error("data pins driven while clock enable low");
	a_autoinit_bound: assert property (dai_ff |-> ai_cnt_ff < CNT_W'(AUTO_INIT_CYC)) // R11
		else $error("auto-init ran past its maximum");
	a_boot_busy: assert property (state_ff == ST_BOOT |-> dai_ff) // R11
		else $error("auto-init status cleared before a reset command");
	a_dai_to_idle: assert property ($fell(dai_ff) && $past(state_ff) == ST_AUTOINIT // R11
		&& state_ff == ST_AUTOINIT |=> state_ff == ST_IDLE)
		else $error("auto-init end did not reach idle");
	a_cal_length: assert property ($rose(ready_ff) |-> $past(cnt_ff) == CNT_W'(INIT_CAL_CYC - 1)) // R16
		else $error("ready raised at wrong calibration count");
	a_cal_pad_info: assert property (s_cal_done |-> calibration_pad_info == CALIBRATION_PAD_INFO_OK && ready_ff) // R22
		else $error("calibration end did not set pad information");
	a_idle_precharged: assert property (state_ff == ST_IDLE |-> bank_open_ff == 8'h00) // R21
		else $error("idle with an open bank");
	a_burst_len: assert property ((state_ff == ST_RD || state_ff == ST_WR) // R02
		|-> beat_ff <= beats_ff)
		else $error("burst ran past its length");
	a_wr_word: assert property (core_wr_valid |-> $past(beat_ff[1:0]) == 2'h3) // R01
		else $error("write word stored before four transfers");
	a_rd_fetch: assert property (s_rd_enter |-> core_rd_strobe ##2 word_ff == $past(core_rd_word)) // R01
		else $error("read burst did not fetch its first core word");

endmodule

// Column of each core word inside a burst, sequential or interleaved.
module lis_burst_col #(
	parameter int COL_W = 10
) (
	input  wire logic [COL_W-1:0] base_col,    // Starting column.
	input  wire logic [1:0]       bl_code,     // 0: four, 1: eight, 2: sixteen transfers.
	input  wire logic             interleave,  // Interleaved order when high.
	input  wire logic [1:0]       word_idx,    // Core word index in the burst.
	output logic      [COL_W-1:0] col          // Column of that word.
);

	logic [3:0] off;
	logic [3:0] mask;
	logic [3:0] low;

	if (COL_W < 5) begin : g_bad_col
		$error("lis_burst_col needs at least five column bits");
	end

	always_comb begin
		off  = {word_idx, 2'b00};
		mask = (bl_code == 2'h2) ? 4'hF : (bl_code == 2'h1) ? 4'h7 : 4'h3;
		low  = interleave ? (base_col[3:0] ^ off) : (base_col[3:0] + off);
		col  = {base_col[COL_W-1:4], (base_col[3:0] & ~mask) | (low & mask)}; // R02
	end

endmodule

// ---- logic/lis_pin_sync.sv ----
module lis_pin_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,    // Core clock.
	input  wire logic         rst,     // Synchronous reset, active high.
	input  wire logic [W-1:0] pin_in,  // Raw pins from outside the clock domain.
	output logic      [W-1:0] pin_out  // Filtered, synchronised pins.
);

	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] out_ff;
	logic [W-1:0] nxt_out;

	if (W < 1) begin : g_bad_w
		$error("lis_pin_sync needs at least one bit");
	end

	// A bit moves only once the second and third stages agree.
	always_comb begin
		nxt_out = (s2_ff & ~(s2_ff ^ s3_ff)) | (out_ff & (s2_ff ^ s3_ff));
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s1_ff  <= '0;
			s2_ff  <= '0;
			s3_ff  <= '0;
			out_ff <= '0;
		end else begin
			s1_ff  <= pin_in;
			s2_ff  <= s1_ff;
			s3_ff  <= s2_ff;
			out_ff <= nxt_out;
		end
	end

	assign pin_out = out_ff;

endmodule

// ---- logic/lis_pkg.sv ----
package lis_pkg;

	// ************************************************************
	// Clock and timing.
	// ************************************************************
	localparam int MCLK_PERIOD_PS        = 8000;
	localparam int AUTO_INIT_MAX_TIME_NS = 10000;
	localparam int AUTO_INIT_CYC         = (AUTO_INIT_MAX_TIME_NS * 1000) / MCLK_PERIOD_PS;
	localparam int INIT_CAL_TIME_NS      = 1000;
	localparam int INIT_CAL_CYC          =
		(INIT_CAL_TIME_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
	localparam int CNT_W                 = 11;

	// ************************************************************
	// Pins, commands and mode registers.
	// ************************************************************
	localparam int       PIN_W     = 22;
	localparam int       CA_W      = 10;
	localparam int       COL_W     = 10;
	localparam logic [3:0] CMD_MRW = 4'h0;
	localparam logic [3:0] CMD_MRR = 4'h8;
	localparam logic [3:0] CMD_PRE = 4'hB;
	localparam logic [2:0] CMD_RD  = 3'h5;
	localparam logic [2:0] CMD_WR  = 3'h1;
	localparam logic [1:0] CMD_ACT = 2'h2;
	localparam int       PRE_ALL_POS = 4;
	localparam logic [7:0] MA_MR0   = 8'h00;
	localparam logic [7:0] MA_MR1   = 8'h01;
	localparam logic [7:0] MA_MR2   = 8'h02;
	localparam logic [7:0] MA_MR3   = 8'h03;
	localparam logic [7:0] MA_MR10  = 8'h0A;
	localparam logic [7:0] MA_RESET = 8'h3F;
	localparam logic [7:0] ZQ_INIT_OP = 8'hFF;
	localparam logic [7:0] MR1_RST  = 8'h02;
	localparam logic [7:0] MR2_RST  = 8'h01;
	localparam logic [7:0] MR3_RST  = 8'h02;
	localparam logic [2:0] BL8_CODE  = 3'h3;
	localparam logic [2:0] BL16_CODE = 3'h4;
	localparam int       MR1_BT_POS = 3;
	localparam logic [1:0] CALIBRATION_PAD_INFO_NONE = 2'h0;
	localparam logic [1:0] CALIBRATION_PAD_INFO_OK   = 2'h3;
	localparam logic [4:0] MRR_BEATS = 5'h04;

	typedef enum logic [2:0] {
		ST_OFF, ST_BOOT, ST_AUTOINIT, ST_IDLE, ST_BANK, ST_ZQCAL, ST_RD, ST_WR
	} lis_state_e;

endpackage

// ---- verif/lis_ctrl_model.sv ----
module lis_ctrl_model
	import lis_pkg::*;
(
	output logic            ck_pin,               // Link clock.
	output logic            cke_pin,              // Clock enable.
	output logic            cs_n_pin,             // Chip select, active low.
	output logic [CA_W-1:0] command_address_bus,  // Command/address pins.
	output logic [7:0]      dq_in,                // Level on the data pins.
	output logic            dm_in,                // Write mask.
	input  wire logic [7:0] dq_out,               // Device read data.
	input  wire logic       dq_oe,                // Device drives data.
	input  wire logic       dqs_out               // Device read strobe.
);
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Link stepping.
	// ************************************************************
	logic [8:0] wq[$];
	logic [8:0] rq[$];
	logic       drv = 1'b0;
	logic [7:0] wb  = 8'h00;

	// A released bus shows the inverse of the last driven byte.
	assign dq_in = dq_oe ? dq_out : (drv ? wb : ~wb);

	initial begin
		ck_pin = 1'b0;
		cke_pin = 1'b0;
		cs_n_pin = 1'b1;
		command_address_bus = 10'h000;
		dm_in = 1'b0;
	end

	// Pins change well after the edge so that the device's sampling lag never races them.
	task automatic step();
		drv = wq.size() > 0;
		if (drv) {dm_in, wb} = wq.pop_front();
		#15.5;
		ck_pin = ~ck_pin;
		#47;
		if (dq_oe) rq.push_back({dqs_out, dq_out});
	endtask

	task automatic cyc(input logic [9:0] r, input logic [9:0] f, input logic sel);
		command_address_bus = r;
		cs_n_pin = ~sel;
		step();
		command_address_bus = f;
		step();
	endtask

	task automatic nop(input int n);
		repeat (n) cyc(10'h000, 10'h000, 1'b0);
	endtask

	task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
		cyc({ma[5:0], CMD_MRW}, {op, ma[7:6]}, 1'b1);
	endtask

	task automatic mrr(input logic [7:0] ma, output logic [7:0] b);
		rq.delete();
		cyc({ma[5:0], CMD_MRR}, {8'h00, ma[7:6]}, 1'b1);
		nop(4);
		b = rq.size() == 4 ? rq[0][7:0] : 8'hEE;
	endtask

	task automatic power_up();
		#0.25; // Keeps every later pin change and sample off the core clock edges.
		nop(8);
		cke_pin = 1'b1;
		nop(1600);
		cyc({5'h01, 1'b1, CMD_PRE}, 10'h000, 1'b1);
		mrw(MA_RESET, 8'h00);
		nop(8);
	endtask
endmodule

// ---- verif/lis_device_tb.sv ----
module lis_device_tb
	import lis_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic             mclk         = 1'b0;
	logic             rst          = 1'b1;
	logic [31:0]      core_rd_word = 32'h0000_0000;
	logic             ck_pin, cke_pin, cs_n_pin, dm_in, dq_oe, dqs_out, dqs_oe;
	logic [CA_W-1:0]  command_address_bus;
	logic [7:0]       dq_in, dq_out;
	logic             core_rd_strobe, core_wr_valid, auto_init_status_bit;
	logic [31:0]      core_wr_word;
	logic [3:0]       core_wr_mask;
	logic [2:0]       core_bank;
	logic [COL_W-1:0] core_col;
	logic [1:0]       calibration_pad_info;
	logic             device_ready, device_idle, all_banks_precharged;
	logic [48:0]      wr_q[$];
	logic [9:0]       rc_q[$];
	int               miscompares = 0;
	int               checks      = 0;

	always #4 mclk = ~mclk;

	lis_device dut_u (.mclk(mclk), .rst(rst), .ck_pin(ck_pin), .cke_pin(cke_pin),
		.cs_n_pin(cs_n_pin), .command_address_bus(command_address_bus), .dq_in(dq_in),
		.dm_in(dm_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out), .dqs_oe(dqs_oe),
		.core_rd_strobe(core_rd_strobe), .core_rd_word(core_rd_word),
		.core_wr_valid(core_wr_valid), .core_wr_word(core_wr_word),
		.core_wr_mask(core_wr_mask), .core_bank(core_bank), .core_col(core_col),
		.auto_init_status_bit(auto_init_status_bit),
		.calibration_pad_info(calibration_pad_info), .device_ready(device_ready),
		.device_idle(device_idle), .all_banks_precharged(all_banks_precharged));

	lis_ctrl_model ctl_u (.ck_pin(ck_pin), .cke_pin(cke_pin), .cs_n_pin(cs_n_pin),
		.command_address_bus(command_address_bus), .dq_in(dq_in), .dm_in(dm_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .dqs_out(dqs_out));

	// ************************************************************
	// Core memory stand-in.
	// ************************************************************
	function automatic logic [31:0] wd(input logic [9:0] c);
		wd = {c[7:0] + 8'h03, c[7:0] + 8'h02, c[7:0] + 8'h01, c[7:0]};
	endfunction

	always @(negedge mclk) if (core_rd_strobe) begin
		core_rd_word <= wd(core_col);
		rc_q.push_back(core_col);
	end

	always @(negedge mclk) if (core_wr_valid) begin
		wr_q.push_back({core_wr_mask, core_bank, core_col, core_wr_word});
	end

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic rdwr(input logic [2:0] op, input logic [9:0] c);
		ctl_u.cyc({3'h2, 1'b0, c[0], 2'b00, op}, {c[9:1], 1'b0}, 1'b1);
	endtask

	task automatic wait_init(input logic [7:0] exp);
		logic [7:0] b;
		int         n;
		n = 0;
		do begin
			ctl_u.mrr(MA_MR0, b);
			n++;
		end while (b !== exp && n < 24);
		chk(b, exp, "auto init done");
		chk(n > 16, 1'b0, "auto init too slow");
		if (n == 24) end_of_test();
	endtask

	task automatic t_boot();
		logic [7:0] b;
		chk({dq_oe, dqs_oe, auto_init_status_bit, calibration_pad_info, device_ready}, 6'h08, "rst");
		ctl_u.power_up();
		ctl_u.mrr(MA_MR0, b);
		chk(b, 8'h01, "init busy");
		rdwr(CMD_RD, 10'h000);
		ctl_u.nop(4);
		chk(rc_q.size(), 0, "read in auto init");
		wait_init(8'h00);
		chk({device_idle, all_banks_precharged}, 2'h3, "idle");
		$display("boot test done");
	endtask

	task automatic t_zq();
		logic [7:0] b;
		ctl_u.mrw(MA_MR10, ZQ_INIT_OP);
		ctl_u.nop(7);
		chk(device_ready, 1'b0, "cal busy");
		ctl_u.nop(2);
		chk({device_ready, calibration_pad_info}, 3'h7, "cal done");
		ctl_u.mrr(MA_MR0, b);
		chk(b, 8'h18, "pad info read");
		$display("calibration test done");
	endtask

	task automatic t_access();
		ctl_u.mrw(MA_MR1, 8'h03);
		ctl_u.mrw(MA_MR2, 8'h01);
		ctl_u.mrw(MA_MR3, 8'h02);
		ctl_u.cyc({3'h2, 5'h00, CMD_ACT}, 10'h000, 1'b1);
		ctl_u.nop(1);
		chk({device_idle, all_banks_precharged}, 2'h0, "bank open");
		rdwr(CMD_WR, 10'h008);
		for (int i = 0; i < 8; i++) ctl_u.wq.push_back({i == 5, 8'h10 + i[7:0]});
		ctl_u.nop(6);
		chk(wr_q.size(), 2, "write words");
		chk(wr_q[0], {4'h0, 3'h2, 10'h008, 32'h1312_1110}, "write word 0");
		chk(wr_q[1], {4'h2, 3'h2, 10'h00C, 32'h1716_1514}, "write word 1");
		ctl_u.rq.delete();
		rdwr(CMD_RD, 10'h004);
		ctl_u.nop(7);
		chk({rc_q.size(), rc_q[0], rc_q[1]}, {32'd2, 10'h004, 10'h000}, "read cols");
		chk(ctl_u.rq.size(), 8, "read beats");
		for (int i = 0; i < 8; i++) chk(ctl_u.rq[i], {~i[0], 8'((i < 4 ? 4 : 0) + i % 4)}, "beat");
		chk(dqs_oe, 1'b0, "strobe released");
		ctl_u.cyc({3'h2, 2'b00, 1'b0, CMD_PRE}, 10'h000, 1'b1);
		ctl_u.nop(1);
		chk({device_idle, all_banks_precharged}, 2'h3, "bank closed");
		ctl_u.cyc({3'h2, 5'h00, CMD_ACT}, 10'h000, 1'b1);
		ctl_u.mrw(MA_MR1, 8'h0C);
		rc_q.delete();
		ctl_u.rq.delete();
		rdwr(CMD_RD, 10'h004);
		ctl_u.nop(9);
		chk(rc_q.size(), 4, "word fetches");
		chk({rc_q[0], rc_q[1]}, {10'h004, 10'h000}, "cols 0 1");
		chk({rc_q[2], rc_q[3]}, {10'h00C, 10'h008}, "cols 2 3");
		chk(ctl_u.rq.size(), 16, "long read beats");
		$display("access test done");
	endtask

	task automatic t_reinit();
		ctl_u.mrw(MA_RESET, 8'h00);
		ctl_u.nop(8);
		chk(auto_init_status_bit, 1'b1, "reinit busy");
		wait_init(8'h18);
		chk({device_idle, all_banks_precharged}, 2'h3, "reinit idle");
		$display("reinit test done");
	endtask

	initial begin
		repeat (16) @(posedge mclk);
		@(negedge mclk);
		rst = 1'b0;
		t_boot();
		t_zq();
		t_access();
		t_reinit();
		end_of_test();
	end

	initial begin
		#400000;
		miscompares++;
		end_of_test();
	end
endmodule
